//--- include/rlase_pkg.sv
package rlase_pkg;
    // register byte offsets
    localparam logic [7:0]  REG_CTRL         = 8'h00;
    localparam logic [7:0]  REG_LINK0        = 8'h08;
    localparam logic [7:0]  REG_LINK1        = 8'h0C;
    localparam logic [7:0]  REG_ERR_STATUS   = 8'h10;
    localparam logic [7:0]  REG_ERR_CLEAR    = 8'h14;
    localparam logic [7:0]  REG_ERR_ENABLE   = 8'h18;
    localparam logic [7:0]  REG_ALIGN_STATUS = 8'h1C;

    // control fields
    localparam int          CTRL_DESCR_OFF_BIT = 9;
    localparam int          CTRL_LOOPBACK_BIT  = 10;

    // link parameter field positions
    localparam int          L_LSB  = 0;
    localparam int          CS_LSB = 4;
    localparam int          HD_BIT = 6;
    localparam int          F_LSB  = 8;
    localparam int          M_LSB  = 16;
    localparam int          E_LSB  = 24;
    localparam int          N_LSB  = 0;
    localparam int          NP_LSB = 8;
    localparam int          S_LSB  = 16;
    localparam int          CF_LSB = 24;
    localparam logic [31:0] LINK0_MASK = 32'hFFFF_FF7F;
    localparam logic [31:0] LINK1_MASK = 32'h1F1F_1F1F;

    // align status field positions
    localparam int          AS_INST_EXT_BIT  = 0;
    localparam int          AS_INST_LANE_BIT = 1;
    localparam int          AS_ALL_EXT_BIT   = 2;
    localparam int          AS_ALL_LANE_BIT  = 3;
    localparam int          AS_LANE_LSB      = 16;

    // link parameter reset values
    localparam logic [3:0]  RST_L  = 4'h2;
    localparam logic [1:0]  RST_CS = 2'h0;
    localparam logic        RST_HD = 1'b0;
    localparam logic [7:0]  RST_F  = 8'h02;
    localparam logic [7:0]  RST_M  = 8'h02;
    localparam logic [7:0]  RST_E  = 8'h01;
    localparam logic [4:0]  RST_N  = 5'h10;
    localparam logic [4:0]  RST_NP = 5'h10;
    localparam logic [4:0]  RST_S  = 5'h01;
    localparam logic [4:0]  RST_CF = 5'h00;

    // test select codes: pattern and care mask
    localparam logic [3:0]  TEST_NORMAL_PAT  = 4'h0;
    localparam logic [3:0]  TEST_NORMAL_CARE = 4'hF;
    localparam logic [3:0]  TEST_DESCR_PAT   = 4'h1;
    localparam logic [3:0]  TEST_DESCR_CARE  = 4'hD;
    localparam logic [3:0]  TEST_LOOP_PAT    = 4'h2;
    localparam logic [3:0]  TEST_LOOP_CARE   = 4'hE;

    // per-lane loopback word width
    localparam int          LANE_BITS = 132;
endpackage

//--- tb/rlase_chk_sva.sv
`timescale 1ns/1ps
module rlase_chk import rlase_pkg::*; #(
    parameter int LANES = 2,
    parameter int ERR_W = 8
) (
    input wire logic                       CORE_CLK_I,
    input wire logic                       RST_N_I,
    input wire logic                       WB_CYC_I,
    input wire logic                       WB_STB_I,
    input wire logic                       WB_WE_I,
    input wire logic                       WB_ACK_O,
    input wire logic [LANES-1:0]           LANE_EXTBLOCK_ALIGNED_I,
    input wire logic [LANES-1:0]           LANE_ALIGNED_I,
    input wire logic [ERR_W-1:0]           RX_ERROR_I,
    input wire logic [LANES*LANE_BITS-1:0] GEARBOX_DATA_I,
    input wire logic [LANES*LANE_BITS-1:0] TX_LOOPBACK_BUS_I,
    input wire logic [LANES*LANE_BITS-1:0] RX_LANE_DATA_O,
    input wire logic                       INST_EXTBLOCK_ALIGNED_O,
    input wire logic                       INST_LANES_ALIGNED_O,
    input wire logic [3:0]                 CFG_LANE_COUNT_O,
    input wire logic [7:0]                 CFG_MULTIBLOCK_PERIOD_O,
    input wire logic [4:0]                 CFG_CTRL_WORDS_PER_FRAME_O,
    input wire logic [3:0]                 CFG_TEST_SELECT_O,
    input wire logic                       TEST_NORMAL_O,
    input wire logic                       DESCRAMBLER_OFF_O,
    input wire logic                       TWO_BLOCK_LOOPBACK_ON_O,
    input wire logic                       ERROR_IRQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence s_ack; WB_ACK_O ##1 !WB_ACK_O; endsequence
    chk_ack_pulse: assert property (s_req |=> s_ack)
        else $error("bus ack is not a one-cycle answer");
    chk_inst_lanes: assert property ($past(RST_N_I) |->
        INST_LANES_ALIGNED_O == $past(&LANE_ALIGNED_I))
        else $error("lanes-aligned output wrong");
    chk_inst_ext: assert property ($past(RST_N_I) |->
        INST_EXTBLOCK_ALIGNED_O == $past(&LANE_EXTBLOCK_ALIGNED_I))
        else $error("extblock-aligned output wrong");
    chk_test_decode: assert property (
        TEST_NORMAL_O == (CFG_TEST_SELECT_O == 4'h0) &&
        DESCRAMBLER_OFF_O == (CFG_TEST_SELECT_O[3:2] == 2'h0 && CFG_TEST_SELECT_O[0]) &&
        TWO_BLOCK_LOOPBACK_ON_O == (CFG_TEST_SELECT_O[3:1] == 3'h1))
        else $error("test select decode wrong");
    chk_data_mux: assert property ($past(RST_N_I) |-> RX_LANE_DATA_O ==
        $past(TWO_BLOCK_LOOPBACK_ON_O ? TX_LOOPBACK_BUS_I : GEARBOX_DATA_I))
        else $error("lane data source wrong");
    chk_irq_rise: assert property ($rose(ERROR_IRQ_O) |->
        $past(|RX_ERROR_I || (WB_ACK_O && WB_WE_I))
        || $fell(INST_LANES_ALIGNED_O) || $fell(INST_EXTBLOCK_ALIGNED_O))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(ERROR_IRQ_O) |->
        $past(WB_ACK_O && WB_WE_I))
        else $error("interrupt fell without a write");
    chk_cfg_static: assert property (!$stable({CFG_LANE_COUNT_O,
        CFG_MULTIBLOCK_PERIOD_O, CFG_CTRL_WORDS_PER_FRAME_O}) |-> $past(WB_ACK_O && WB_WE_I))
        else $error("link parameter moved without a write");
endmodule
bind rlase_top rlase_chk #(.LANES(LANES), .ERR_W(ERR_W)) rlase_chk_i (.*);

//--- tb/rlase_far.sv
`timescale 1ns/1ps
module rlase_far import rlase_pkg::*; #(
    parameter int LANES = 2
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       inst_ext_i,
    input  wire logic                       inst_lane_i,
    input  wire logic                       peer_ok_i,
    output logic                            all_ext_o,
    output logic                            all_lane_o,
    output logic      [LANES*LANE_BITS-1:0] tx_loop_o
);
    // other instances folded into one peer flag
    assign all_ext_o  = inst_ext_i & peer_ok_i;
    assign all_lane_o = inst_lane_i & peer_ok_i;
    // paired transmitter, new word every cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_loop_o <= '0;
        end else begin
            tx_loop_o <= {tx_loop_o[LANES*LANE_BITS-2:0], ~tx_loop_o[LANES*LANE_BITS-1]};
        end
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench import rlase_pkg::*;;
    localparam int W = 2 * LANE_BITS;
    logic         clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]   adr = 8'h00, err = 8'h00, cfg_f, cfg_m, cfg_e;
    logic [31:0]  wdat = 32'h0, rdat, q, l0, l1, en, e, seed = 32'h2E3F;
    logic [1:0]   lal = 2'h0, lext = 2'h0, la, le, cfg_cs;
    logic [4:0]   cfg_n, cfg_np, cfg_s, cfg_cf;
    logic [3:0]   cfg_l, tsel, sel = 4'hF;
    logic [W-1:0] gear = '0, txb, rx, txs;
    logic [287:0] r;
    logic         ack, iext, ilane, all_ext, all_lane, cfg_hd, tnorm, doff, lbon, irq, peer = 1'b0;
    int           fail_count = 0, n_tests = 0, i, j;

    always #20 clk = ~clk;
    rlase_top #(.LANES(2), .ERR_W(8), .MULTILINK(1'b1), .SIMPLEX(1'b1)) rlase_top_i (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .LANE_EXTBLOCK_ALIGNED_I(lext), .LANE_ALIGNED_I(lal), .ALL_INST_EXTBLOCK_ALIGNED_I(all_ext),
        .ALL_INST_LANES_ALIGNED_I(all_lane), .RX_ERROR_I(err), .GEARBOX_DATA_I(gear),
        .TX_LOOPBACK_BUS_I(txb), .TX_INTERNAL_LOOPBACK_I({W{1'b0}}), .RX_LANE_DATA_O(rx),
        .INST_EXTBLOCK_ALIGNED_O(iext), .INST_LANES_ALIGNED_O(ilane), .CFG_LANE_COUNT_O(cfg_l),
        .CFG_OCTETS_PER_FRAME_O(cfg_f), .CFG_CONVERTER_COUNT_O(cfg_m),
        .CFG_CTRL_BITS_PER_SAMPLE_O(cfg_cs), .CFG_CONVERTER_RESOLUTION_O(cfg_n),
        .CFG_TOTAL_BITS_PER_SAMPLE_O(cfg_np), .CFG_SAMPLES_PER_FRAME_O(cfg_s),
        .CFG_HIGH_DENSITY_O(cfg_hd), .CFG_CTRL_WORDS_PER_FRAME_O(cfg_cf),
        .CFG_MULTIBLOCK_PERIOD_O(cfg_e), .CFG_TEST_SELECT_O(tsel), .TEST_NORMAL_O(tnorm),
        .DESCRAMBLER_OFF_O(doff), .TWO_BLOCK_LOOPBACK_ON_O(lbon), .ERROR_IRQ_O(irq));
    rlase_far #(.LANES(2)) rlase_far_i (.clk_i(clk), .rst_n_i(rst_n), .inst_ext_i(iext),
        .inst_lane_i(ilane), .peer_ok_i(peer), .all_ext_o(all_ext), .all_lane_o(all_lane),
        .tx_loop_o(txb));

    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cfgchk;
        logic [31:0] d;
        wb(1'b0, REG_LINK0, 32'h0, d);
        chk(d, l0);
        chk({cfg_e, cfg_m, cfg_f, 1'b0, cfg_hd, cfg_cs, cfg_l}, l0);
        wb(1'b0, REG_LINK1, 32'h0, d);
        chk(d, l1);
        chk({3'h0, cfg_cf, 3'h0, cfg_s, 3'h0, cfg_np, 3'h0, cfg_n}, l1);
    endtask

    task automatic report_and_stop;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        l0 = {RST_E, RST_M, RST_F, 1'b0, RST_HD, RST_CS, RST_L};
        l1 = {3'h0, RST_CF, 3'h0, RST_S, 3'h0, RST_NP, 3'h0, RST_N};
        cfgchk();
        wb(1'b1, 8'h04, 32'hFFFF_FFFF, q);
        wb(1'b0, 8'h04, 32'h0, q);
        chk(q, 32'h0);
        for (i = 0; i < 5; i++) begin
            l0 = $random(seed) & LINK0_MASK;
            l1 = $random(seed) & LINK1_MASK;
            wb(1'b1, REG_LINK0, l0, q);
            wb(1'b1, REG_LINK1, l1, q);
            cfgchk();
        end
        // byte enable: only the low byte of link1 may change
        sel <= 4'h1;
        l1 = (l1 & 32'hFFFF_FF00) | (32'h5A & LINK1_MASK);
        wb(1'b1, REG_LINK1, 32'hA5A5_A55A, q);
        sel <= 4'hF;
        cfgchk();
        for (i = 0; i < 4; i++) begin
            wb(1'b1, REG_CTRL, i << 9, q);
            wb(1'b0, REG_CTRL, 32'h0, q);
            chk(q, i << 9);
            chk(tsel, i);
            chk({tnorm, doff, lbon}, {i == 0, i[0], i[1]});
            for (j = 0; j < 9; j++) begin
                r[j*32+:32] = $random(seed);
            end
            gear <= r[W-1:0];
            @(posedge clk);
            @(posedge clk);
            txs = txb;
            @(posedge clk);
            chk(rx, i[1] ? txs : gear);
            chk(rx[LANE_BITS-1:0], i[1] ? txs[LANE_BITS-1:0] : gear[LANE_BITS-1:0]);
        end
        for (i = 0; i < 16; i++) begin
            la = 2'($random(seed));
            le = 2'($random(seed));
            lal <= la;
            lext <= le;
            peer <= i[2];
            @(posedge clk);
            @(posedge clk);
            chk(ilane, &la);
            chk(iext, &le);
            wb(1'b0, REG_ALIGN_STATUS, 32'h0, q);
            chk(q, {14'h0, la, 12'h0, &la & i[2], &le & i[2], &la, &le});
        end
        wb(1'b1, REG_ERR_CLEAR, 32'hFFFF_FFFF, q);
        for (i = 0; i < 12; i++) begin
            en = $random(seed) & 32'hFF;
            e = $random(seed) & 32'hFF;
            wb(1'b1, REG_ERR_ENABLE, en, q);
            err <= e[7:0];
            @(posedge clk);
            err <= 8'h00;
            @(posedge clk);
            chk(irq, |(e & en));
            wb(1'b0, REG_ERR_STATUS, 32'h0, q);
            chk(q, e);
            wb(1'b0, REG_ERR_ENABLE, 32'h0, q);
            chk(q, en);
            wb(1'b1, REG_ERR_CLEAR, e, q);
            chk(irq, 1'b0);
        end
        // error event at the clearing edge: the set wins
        wb(1'b1, REG_ERR_ENABLE, 32'h1, q);
        fork
            wb(1'b1, REG_ERR_CLEAR, 32'h1, q);
            begin
                @(posedge clk);
                err <= 8'h01;
                @(posedge clk);
                err <= 8'h00;
            end
        join
        wb(1'b0, REG_ERR_STATUS, 32'h0, q);
        chk(q, 32'h1);
        chk(irq, 1'b1);
        // reset in mid-run restores every register
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(irq, 1'b0);
        chk(tsel, 4'h0);
        chk(tnorm, 1'b1);
        l0 = {RST_E, RST_M, RST_F, 1'b0, RST_HD, RST_CS, RST_L};
        l1 = {3'h0, RST_CF, 3'h0, RST_S, 3'h0, RST_NP, 3'h0, RST_N};
        cfgchk();
        report_and_stop();
    end
endmodule

//--- verilog/rlase_lb_mux.sv
`timescale 1ns/1ps
module rlase_lb_mux import rlase_pkg::*; #(
    parameter int LANES   = 2,
    parameter bit SIMPLEX = 1'b1
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       loop_sel_i,
    input  wire logic [LANES*LANE_BITS-1:0] gearbox_i,
    input  wire logic [LANES*LANE_BITS-1:0] ext_loop_i,
    input  wire logic [LANES*LANE_BITS-1:0] int_loop_i,
    output logic      [LANES*LANE_BITS-1:0] data_o
);
    typedef struct packed {
        logic [LANES*LANE_BITS-1:0] data;
    } rlase_mux_s;

    rlase_mux_s s;
    rlase_mux_s next_s;

    always_comb begin
        next_s = s;
        if (loop_sel_i) begin
            next_s.data = SIMPLEX ? ext_loop_i : int_loop_i;
        end else begin
            next_s.data = gearbox_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign data_o = s.data;
endmodule

//--- verilog/rlase_top.sv
`timescale 1ns/1ps
module rlase_top import rlase_pkg::*; #(
    parameter int LANES     = 2,
    parameter int ERR_W     = 8,
    parameter bit MULTILINK = 1'b1,
    parameter bit SIMPLEX   = 1'b1
) (
    input  wire logic                       CORE_CLK_I,
    input  wire logic                       RST_N_I,
    input  wire logic                       WB_CYC_I,
    input  wire logic                       WB_STB_I,
    input  wire logic                       WB_WE_I,
    input  wire logic [7:0]                 WB_ADR_I,
    input  wire logic [3:0]                 WB_SEL_I,
    input  wire logic [31:0]                WB_DAT_I,
    output logic      [31:0]                WB_DAT_O,
    output logic                            WB_ACK_O,
    input  wire logic [LANES-1:0]           LANE_EXTBLOCK_ALIGNED_I,
    input  wire logic [LANES-1:0]           LANE_ALIGNED_I,
    input  wire logic                       ALL_INST_EXTBLOCK_ALIGNED_I,
    input  wire logic                       ALL_INST_LANES_ALIGNED_I,
    input  wire logic [ERR_W-1:0]           RX_ERROR_I,
    input  wire logic [LANES*LANE_BITS-1:0] GEARBOX_DATA_I,
    input  wire logic [LANES*LANE_BITS-1:0] TX_LOOPBACK_BUS_I,
    input  wire logic [LANES*LANE_BITS-1:0] TX_INTERNAL_LOOPBACK_I,
    output logic      [LANES*LANE_BITS-1:0] RX_LANE_DATA_O,
    output logic                            INST_EXTBLOCK_ALIGNED_O,
    output logic                            INST_LANES_ALIGNED_O,
    output logic      [3:0]                 CFG_LANE_COUNT_O,
    output logic      [7:0]                 CFG_OCTETS_PER_FRAME_O,
    output logic      [7:0]                 CFG_CONVERTER_COUNT_O,
    output logic      [1:0]                 CFG_CTRL_BITS_PER_SAMPLE_O,
    output logic      [4:0]                 CFG_CONVERTER_RESOLUTION_O,
    output logic      [4:0]                 CFG_TOTAL_BITS_PER_SAMPLE_O,
    output logic      [4:0]                 CFG_SAMPLES_PER_FRAME_O,
    output logic                            CFG_HIGH_DENSITY_O,
    output logic      [4:0]                 CFG_CTRL_WORDS_PER_FRAME_O,
    output logic      [7:0]                 CFG_MULTIBLOCK_PERIOD_O,
    output logic      [3:0]                 CFG_TEST_SELECT_O,
    output logic                            TEST_NORMAL_O,
    output logic                            DESCRAMBLER_OFF_O,
    output logic                            TWO_BLOCK_LOOPBACK_ON_O,
    output logic                            ERROR_IRQ_O
);
    // error status: external errors, then lane-align lost, extblock-align lost
    localparam int STAT_W = ERR_W + 2;

    localparam logic [31:0] LINK0_RST = (32'(RST_L) << L_LSB) | (32'(RST_CS) << CS_LSB)
                                      | (32'(RST_HD) << HD_BIT) | (32'(RST_F) << F_LSB)
                                      | (32'(RST_M) << M_LSB) | (32'(RST_E) << E_LSB);
    localparam logic [31:0] LINK1_RST = (32'(RST_N) << N_LSB) | (32'(RST_NP) << NP_LSB)
                                      | (32'(RST_S) << S_LSB) | (32'(RST_CF) << CF_LSB);

    typedef struct packed {
        logic              ack;
        logic [31:0]       rdata;
        logic              descr_off;
        logic              loopback;
        logic [31:0]       link0;
        logic [31:0]       link1;
        logic [STAT_W-1:0] err_status;
        logic [STAT_W-1:0] err_enable;
        logic              ext_aligned;
        logic              lanes_aligned;
    } rlase_state_s;

    rlase_state_s s;
    rlase_state_s next_s;

    logic              req;
    logic              wr;
    logic [31:0]       wmerge_ctrl;
    logic [STAT_W-1:0] clr;
    logic [STAT_W-1:0] events;
    logic [3:0]        test_code;

    // byte-lane merge of a write into a stored word, reserved bits kept zero
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel,
                                             input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return r & mask;
    endfunction

    // true when every lane bit is set
    function automatic logic all_lanes(input logic [LANES-1:0] v);
        return &v;
    endfunction

    // match a test code against pattern under a care mask
    function automatic logic test_is(input logic [3:0] code,
                                     input logic [3:0] pat,
                                     input logic [3:0] care);
        return ((code ^ pat) & care) == 4'h0;
    endfunction

    function automatic logic [31:0] stat_word(input logic [STAT_W-1:0] v);
        return 32'(v);
    endfunction

    assign req       = WB_CYC_I & WB_STB_I;
    assign wr        = req & s.ack & WB_WE_I;
    assign test_code = {2'b00, s.loopback, s.descr_off};
    assign wmerge_ctrl = wb_merge({21'h0, s.loopback, s.descr_off, 9'h0}, WB_DAT_I,
                                  WB_SEL_I, 32'h0000_0600);

    always_comb begin
        next_s = s;
        clr    = '0;
        events = '0;

        // alignment tracking
        next_s.lanes_aligned = all_lanes(LANE_ALIGNED_I);
        if (MULTILINK) begin
            next_s.ext_aligned = all_lanes(LANE_EXTBLOCK_ALIGNED_I);
        end else begin
            next_s.ext_aligned = 1'b0;
        end

        // bus answer one cycle after request, then drop
        next_s.ack = req & ~s.ack;
        if (req & ~s.ack) begin
            case (WB_ADR_I)
                REG_CTRL: begin
                    next_s.rdata = {21'h0, s.loopback, s.descr_off, 9'h0};
                end
                REG_LINK0: begin
                    next_s.rdata = s.link0;
                end
                REG_LINK1: begin
                    next_s.rdata = s.link1;
                end
                REG_ERR_STATUS: begin
                    next_s.rdata = stat_word(s.err_status);
                end
                REG_ERR_ENABLE: begin
                    next_s.rdata = stat_word(s.err_enable);
                end
                REG_ALIGN_STATUS: begin
                    next_s.rdata = '0;
                    next_s.rdata[AS_INST_EXT_BIT]  = s.ext_aligned;
                    next_s.rdata[AS_INST_LANE_BIT] = s.lanes_aligned;
                    next_s.rdata[AS_ALL_EXT_BIT]   = ALL_INST_EXTBLOCK_ALIGNED_I;
                    next_s.rdata[AS_ALL_LANE_BIT]  = ALL_INST_LANES_ALIGNED_I;
                    next_s.rdata[AS_LANE_LSB +: LANES] = LANE_ALIGNED_I;
                end
                default: begin
                    next_s.rdata = '0;
                end
            endcase
        end

        // register writes take effect at the acknowledging edge
        if (wr) begin
            case (WB_ADR_I)
                REG_CTRL: begin
                    next_s.loopback  = wmerge_ctrl[CTRL_LOOPBACK_BIT];
                    next_s.descr_off = wmerge_ctrl[CTRL_DESCR_OFF_BIT];
                end
                REG_LINK0: begin
                    next_s.link0 = wb_merge(s.link0, WB_DAT_I, WB_SEL_I, LINK0_MASK);
                end
                REG_LINK1: begin
                    next_s.link1 = wb_merge(s.link1, WB_DAT_I, WB_SEL_I, LINK1_MASK);
                end
                REG_ERR_CLEAR: begin
                    clr = STAT_W'(wb_merge(32'h0, WB_DAT_I, WB_SEL_I, 32'hFFFF_FFFF));
                end
                REG_ERR_ENABLE: begin
                    next_s.err_enable = STAT_W'(wb_merge(stat_word(s.err_enable), WB_DAT_I,
                                                         WB_SEL_I, 32'hFFFF_FFFF));
                end
                default: begin
                end
            endcase
        end

        // sticky errors, a new event beats a clear in the same cycle
        events[ERR_W-1:0] = RX_ERROR_I;
        events[ERR_W]     = s.lanes_aligned & ~next_s.lanes_aligned;
        events[ERR_W+1]   = s.ext_aligned & ~next_s.ext_aligned;
        next_s.err_status = (s.err_status & ~clr) | events;
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            s            <= '0;
            s.link0      <= LINK0_RST;
            s.link1      <= LINK1_RST;
        end else begin
            s <= next_s;
        end
    end

    // bus outputs
    assign WB_ACK_O = s.ack;
    assign WB_DAT_O = s.rdata;

    // alignment outputs
    assign INST_EXTBLOCK_ALIGNED_O = s.ext_aligned;
    assign INST_LANES_ALIGNED_O    = s.lanes_aligned;

    // exported link parameters, held static by software during operation
    assign CFG_LANE_COUNT_O            = s.link0[L_LSB +: 4];
    assign CFG_CTRL_BITS_PER_SAMPLE_O  = s.link0[CS_LSB +: 2];
    assign CFG_OCTETS_PER_FRAME_O      = s.link0[F_LSB +: 8];
    assign CFG_CONVERTER_COUNT_O       = s.link0[M_LSB +: 8];
    assign CFG_HIGH_DENSITY_O          = s.link0[HD_BIT];
    assign CFG_MULTIBLOCK_PERIOD_O     = s.link0[E_LSB +: 8];
    assign CFG_CONVERTER_RESOLUTION_O  = s.link1[N_LSB +: 5];
    assign CFG_TOTAL_BITS_PER_SAMPLE_O = s.link1[NP_LSB +: 5];
    assign CFG_SAMPLES_PER_FRAME_O     = s.link1[S_LSB +: 5];
    assign CFG_CTRL_WORDS_PER_FRAME_O  = s.link1[CF_LSB +: 5];

    // test select decode
    assign CFG_TEST_SELECT_O       = test_code;
    assign TEST_NORMAL_O           = test_is(test_code, TEST_NORMAL_PAT, TEST_NORMAL_CARE);
    assign DESCRAMBLER_OFF_O       = test_is(test_code, TEST_DESCR_PAT, TEST_DESCR_CARE);
    assign TWO_BLOCK_LOOPBACK_ON_O = test_is(test_code, TEST_LOOP_PAT, TEST_LOOP_CARE);

    // interrupt from enabled sticky errors
    assign ERROR_IRQ_O = |(s.err_status & s.err_enable);

    // gearbox versus loopback data
    rlase_lb_mux #(
        .LANES   (LANES),
        .SIMPLEX (SIMPLEX)
    ) u_lb_mux (
        .clk_i      (CORE_CLK_I),
        .rst_n_i    (RST_N_I),
        .loop_sel_i (TWO_BLOCK_LOOPBACK_ON_O),
        .gearbox_i  (GEARBOX_DATA_I),
        .ext_loop_i (TX_LOOPBACK_BUS_I),
        .int_loop_i (TX_INTERNAL_LOOPBACK_I),
        .data_o     (RX_LANE_DATA_O)
    );
endmodule
